// ---- verilog/cssr_consts.svh ----
`ifndef CSSR_CONSTS_SVH
`define CSSR_CONSTS_SVH
// Register byte addresses
`define CSSR_A_CTRL   14'h0000
`define CSSR_A_CFG    14'h0004
`define CSSR_A_STAT   14'h0008
`define CSSR_A_CNG    14'h000c
`define CSSR_A_GAIN   14'h0010
`define CSSR_A_DEEMPH 14'h0014
`define CSSR_A_WSYN   14'h0018
// Buffer window: region bit, buffer id, word index
`define CSSR_BUF_BIT  13
`define CSSR_BUF_ID   12:11
`define CSSR_BUF_IDX  10:2
// Frame configuration fields
`define CSSR_CFG_RATE 2:0
`define CSSR_CFG_LEG  3
`define CSSR_CFG_CORE 5:4
`define CSSR_CFG_BR   9:6
`define CSSR_CFG_NSEG 10
`define CSSR_CFG_W    10:0
`define CSSR_CFG_RST  11'h001
// Internal rate codes
`define CSSR_R8K   3'h0
`define CSSR_R12K8 3'h1
`define CSSR_R16K  3'h2
`define CSSR_R25K6 3'h3
`define CSSR_R32K  3'h4
`define CSSR_R48K  3'h5
// Bit-rate codes
`define CSSR_BR_7K2  4'h1
`define CSSR_BR_8K   4'h2
`define CSSR_BR_9K6  4'h3
`define CSSR_BR_13K2 4'h4
`define CSSR_BR_16K4 4'h5
`define CSSR_BR_24K4 4'h6
`define CSSR_BR_32K  4'h7
`define CSSR_BR_64K  4'h9
// Synthesis history lengths, floor(1.25 ms * rate)
`define CSSR_SYN_LEN 9'h03c
`define CSSR_SYN_N0  9'h00a
`define CSSR_SYN_N1  9'h010
`define CSSR_SYN_N2  9'h014
`define CSSR_SYN_N3  9'h020
`define CSSR_SYN_N4  9'h028
`define CSSR_SYN_N5  9'h03c
// Transform past-signal lengths (5 ms)
`define CSSR_TCX_N0  9'h028
`define CSSR_TCX_N1  9'h040
`define CSSR_TCX_N2  9'h050
`define CSSR_TCX_N3  9'h080
`define CSSR_TCX_N4  9'h0a0
`define CSSR_TCX_N5  9'h0f0
// Adaptive codebook, one 20 ms frame
`define CSSR_ACB_12K8 9'h100
`define CSSR_ACB_16K  9'h140
// Engine constants
`define CSSR_DIV_LAST 5'h18
`define CSSR_HALF     27'h0008000
`define CSSR_LAST_JOB 2'h3
`define CSSR_CNG_MAX  8'h3f
`define CSSR_GAIN_INI 16'hf200
`define CSSR_SAFE_N   2'h3
`define CSSR_BUSY_MAX 12'hc00
`endif

// ---- verilog/cssr_pkg.sv ----
package cssr_pkg;
  // Engine sequence
  typedef enum logic [2:0] {
    st_idle, st_setup, st_div, st_copy, st_interp, st_mode
  } cssr_state_e;
  // Core coder of a frame
  typedef enum logic [1:0] {
    algebraic_celp, transform_excitation_mode,
    high_quality_transform_mode
  } cssr_core_e;
  // Transform to CELP transition selection
  typedef enum logic [1:0] {
    tm_none, transition_mode_one, transition_mode_two,
    transition_mode_three
  } cssr_tmode_e;
  // Whole block state
  typedef struct packed {
    cssr_state_e        st;
    logic [10:0]        cfg;
    logic [10:0]        prev;
    logic [1:0]         job;
    logic               zero;
    logic [8:0]         no;
    logic [8:0]         nn;
    logic [8:0]         so;
    logic [8:0]         dofs;
    logic [24:0]        dq;
    logic [9:0]         rem;
    logic [4:0]         dcnt;
    logic signed [26:0] pos;
    logic [8:0]         cnt;
    cssr_tmode_e        tmode;
    logic               rsw;
    logic               recomp;
    logic               acb_zero;
    logic               to_legacy;
    logic               to_primary;
    logic               sid_force;
    logic               ar_reset;
    logic               bwe_reset;
    logic [7:0]         comfort_noise;
    logic [15:0]        gain;
    logic [15:0]        deemph;
    logic [15:0]        wsyn;
    logic [1:0]         safety;
    logic [31:0]        rdata;
    logic [11:0]        busy_cnt;
  } cssr_state_s;
endpackage : cssr_pkg

// ---- verilog/cssr_resampler.sv ----
// How it works
// - Sample is base plus fraction times step
// - Position starts half ratio minus half
// - Output index from zero, floor gives source
// - Odd rate involved clears weighted state
// - Listed bit-rates keep weighted state
// - Otherwise weighted state flagged for recompute
// - Past input and weighted signals resampled
// - Codebook interpolated between 12.8 and 16
// - Codebook zeroed when odd rate involved
// - Synthesis history held as 60 samples
// - Tail lengths from 1.25 ms per rate
// - History refilled per frame, resampled next
// - De-emphasis memory never touched here
// - Legacy entry flags immittance conversion
// - Legacy entry clamps energy, sets gain
// - Noise segment forces silence descriptor frame
// - Three safety-net frames after leaving legacy
// - Primary return flags conversion and resets
// - Rate memory work before other switching
// - Listed bit-rates select transition mode one
// - Other rates select mode two or three
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "cssr_consts.svh"
module cssr_resampler #(
  parameter int DEPTH = 320
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [13:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             busy
);
  // Registered state and its next value
  cssr_pkg::cssr_state_s state_ff;
  cssr_pkg::cssr_state_s nxt_state;
  // Four history buffers; buffer 0 is synthesis
  logic signed [15:0] buf_mem [0:3][0:DEPTH-1];
  logic signed [15:0] scr_mem [0:DEPTH-1]; // Copy of source
  // Memory write controls from the combinational block
  logic               mem_we;
  logic [1:0]         mem_buf;
  logic [8:0]         mem_idx;
  logic signed [15:0] mem_wd;
  logic               scr_we;
  logic [8:0]         scr_idx;
  logic signed [15:0] scr_wd;
  logic               go;      // Frame start accepted

  // Synthesis tail length per rate
  function automatic logic [8:0] syn_len(input logic [2:0] r);
    case (r)
      `CSSR_R8K:   syn_len = `CSSR_SYN_N0;
      `CSSR_R12K8: syn_len = `CSSR_SYN_N1;
      `CSSR_R16K:  syn_len = `CSSR_SYN_N2;
      `CSSR_R25K6: syn_len = `CSSR_SYN_N3;
      `CSSR_R32K:  syn_len = `CSSR_SYN_N4;
      default:     syn_len = `CSSR_SYN_N5;
    endcase
  endfunction : syn_len

  // Transform past length per rate
  function automatic logic [8:0] tcx_len(input logic [2:0] r);
    case (r)
      `CSSR_R8K:   tcx_len = `CSSR_TCX_N0;
      `CSSR_R12K8: tcx_len = `CSSR_TCX_N1;
      `CSSR_R16K:  tcx_len = `CSSR_TCX_N2;
      `CSSR_R25K6: tcx_len = `CSSR_TCX_N3;
      `CSSR_R32K:  tcx_len = `CSSR_TCX_N4;
      default:     tcx_len = `CSSR_TCX_N5;
    endcase
  endfunction : tcx_len

  // Rate is one of the two CELP core rates
  function automatic logic is_std(input logic [2:0] r);
    is_std = (r == `CSSR_R12K8) || (r == `CSSR_R16K);
  endfunction : is_std

  // Bit-rates where the weighted state keeps its update
  function automatic logic keep_br(input logic [3:0] b);
    keep_br = (b <= `CSSR_BR_8K) || (b == `CSSR_BR_13K2) ||
              (b == `CSSR_BR_32K) || (b == `CSSR_BR_64K);
  endfunction : keep_br

  // Bit-rates that take the first transition mode
  function automatic logic one_br(input logic [3:0] b);
    one_br = (b == `CSSR_BR_7K2) || (b == `CSSR_BR_8K) ||
             (b == `CSSR_BR_13K2) || (b == `CSSR_BR_32K) ||
             (b == `CSSR_BR_64K);
  endfunction : one_br

  // Bit-rates that take mode two or three
  function automatic logic two_br(input logic [3:0] b);
    two_br = (b == `CSSR_BR_9K6) || (b == `CSSR_BR_16K4) ||
             (b == `CSSR_BR_24K4);
  endfunction : two_br

  // Next state, bus decode and resampling datapath
  always_comb begin
    logic [2:0]         pr;
    logic [2:0]         cr;
    logic [9:0]         t;
    logic               qb;
    logic [24:0]        r;
    logic [8:0]         i0;
    logic [8:0]         i1;
    logic [15:0]        frac;
    logic signed [15:0] a;
    logic signed [15:0] b;
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    logic [1:0]         pcore;
    logic [1:0]         ccore;
    pr = state_ff.prev[`CSSR_CFG_RATE];
    cr = state_ff.cfg[`CSSR_CFG_RATE];
    t = '0;
    qb = 1'b0;
    r = '0;
    i0 = '0;
    i1 = '0;
    frac = '0;
    a = '0;
    b = '0;
    diff = '0;
    prod = '0;
    pcore = state_ff.prev[`CSSR_CFG_CORE];
    ccore = state_ff.cfg[`CSSR_CFG_CORE];
    nxt_state = state_ff;
    mem_we = 1'b0;
    mem_buf = state_ff.job;
    mem_idx = '0;
    mem_wd = '0;
    scr_we = 1'b0;
    scr_idx = '0;
    scr_wd = '0;
    go = wr && (addr == `CSSR_A_CTRL) && wdata[0] &&
         (state_ff.st == cssr_pkg::st_idle);
    // Register and buffer writes, only while idle
    if (wr && state_ff.st == cssr_pkg::st_idle) begin
      if (addr[`CSSR_BUF_BIT]) begin
        if (32'(addr[`CSSR_BUF_IDX]) < DEPTH) begin
          mem_we = 1'b1;
          mem_buf = addr[`CSSR_BUF_ID];
          mem_idx = addr[`CSSR_BUF_IDX];
          mem_wd = wdata[15:0];
        end
      end else begin
        case (addr)
          `CSSR_A_CFG:    nxt_state.cfg = wdata[`CSSR_CFG_W];
          `CSSR_A_CNG:    nxt_state.comfort_noise = wdata[7:0];
          `CSSR_A_GAIN:   nxt_state.gain = wdata[15:0];
          `CSSR_A_DEEMPH: nxt_state.deemph = wdata[15:0];
          `CSSR_A_WSYN:   nxt_state.wsyn = wdata[15:0];
          default:        ;
        endcase
      end
    end
    // Read data stands in the following cycle only
    nxt_state.rdata = '0;
    if (rd) begin
      if (addr[`CSSR_BUF_BIT]) begin
        if (32'(addr[`CSSR_BUF_IDX]) < DEPTH) begin
          nxt_state.rdata = 32'(
            buf_mem[addr[`CSSR_BUF_ID]][addr[`CSSR_BUF_IDX]]);
        end
      end else begin
        case (addr)
          `CSSR_A_CFG:    nxt_state.rdata = 32'(state_ff.cfg);
          `CSSR_A_STAT:   nxt_state.rdata = 32'({
            state_ff.safety,
            (state_ff.safety != 2'h0) && (ccore == 2'h0),
            state_ff.bwe_reset, state_ff.ar_reset,
            state_ff.sid_force, state_ff.to_primary,
            state_ff.to_legacy, state_ff.acb_zero,
            state_ff.recomp, state_ff.rsw, state_ff.tmode,
            state_ff.st != cssr_pkg::st_idle});
          `CSSR_A_CNG:    nxt_state.rdata = 32'(state_ff.comfort_noise);
          `CSSR_A_GAIN:   nxt_state.rdata = 32'(state_ff.gain);
          `CSSR_A_DEEMPH: nxt_state.rdata = 32'(state_ff.deemph);
          `CSSR_A_WSYN:   nxt_state.rdata = 32'(state_ff.wsyn);
          default:        nxt_state.rdata = '0;
        endcase
      end
    end
    // Cycle counter of one frame-start job
    if (state_ff.st != cssr_pkg::st_idle) begin
      nxt_state.busy_cnt = state_ff.busy_cnt + 12'h001;
    end
    unique case (state_ff.st)
      cssr_pkg::st_idle: begin
        if (go) begin
          // Compare rate at the frame boundary
          nxt_state.busy_cnt = '0;
          nxt_state.job = '0;
          nxt_state.acb_zero = 1'b0;
          nxt_state.rsw = (pr != cr);
          nxt_state.st = (pr != cr) ? cssr_pkg::st_setup
                                    : cssr_pkg::st_mode;
        end
      end
      cssr_pkg::st_setup: begin
        nxt_state.zero = 1'b0;
        nxt_state.cnt = '0;
        nxt_state.so = '0;
        nxt_state.dofs = '0;
        case (state_ff.job)
          2'h0: begin
            // Tail of old length into new tail
            nxt_state.no = syn_len(pr);
            nxt_state.nn = syn_len(cr);
            nxt_state.so = `CSSR_SYN_LEN - syn_len(pr);
            nxt_state.dofs = `CSSR_SYN_LEN - syn_len(cr);
          end
          2'h1: begin
            if (is_std(pr) && is_std(cr)) begin
              nxt_state.no = pr == `CSSR_R16K ? `CSSR_ACB_16K
                                              : `CSSR_ACB_12K8;
              nxt_state.nn = cr == `CSSR_R16K ? `CSSR_ACB_16K
                                              : `CSSR_ACB_12K8;
            end else begin
              nxt_state.zero = 1'b1;
              nxt_state.acb_zero = 1'b1;
              nxt_state.nn = 9'(DEPTH);
            end
          end
          default: begin
            nxt_state.no = tcx_len(pr);
            nxt_state.nn = tcx_len(cr);
          end
        endcase
        nxt_state.dq = {nxt_state.no, 16'h0000};
        nxt_state.rem = '0;
        nxt_state.dcnt = '0;
        nxt_state.st = nxt_state.zero ? cssr_pkg::st_interp
                                      : cssr_pkg::st_div;
      end
      cssr_pkg::st_div: begin
        // Restoring divide gives old over new in Q16
        t = {state_ff.rem[8:0], state_ff.dq[24]};
        if (t >= {1'b0, state_ff.nn}) begin
          t = t - {1'b0, state_ff.nn};
          qb = 1'b1;
        end
        r = {state_ff.dq[23:0], qb};
        nxt_state.rem = t;
        nxt_state.dq = r;
        nxt_state.dcnt = state_ff.dcnt + 5'h01;
        if (state_ff.dcnt == `CSSR_DIV_LAST) begin
          // Start at half the ratio minus half
          // Ratios reach six, so nineteen quotient bits count
          nxt_state.pos = $signed({9'h000, r[18:1]}) -
                          $signed(`CSSR_HALF);
          nxt_state.st = cssr_pkg::st_copy;
        end
      end
      cssr_pkg::st_copy: begin
        // Source copied aside so writes cannot overrun it
        scr_we = 1'b1;
        scr_idx = state_ff.cnt;
        scr_wd = buf_mem[state_ff.job][9'(state_ff.so +
                                          state_ff.cnt)];
        nxt_state.cnt = state_ff.cnt + 9'h001;
        if (state_ff.cnt == state_ff.no - 9'h001) begin
          nxt_state.cnt = '0;
          nxt_state.st = cssr_pkg::st_interp;
        end
      end
      cssr_pkg::st_interp: begin
        // Source index is the floor of position
        if (!state_ff.pos[26]) begin
          i0 = state_ff.pos[24:16];
          frac = state_ff.pos[15:0];
        end
        // Clamp at the buffer edges, slope taken as flat
        if (i0 >= state_ff.no) begin
          i0 = state_ff.no - 9'h001;
        end
        i1 = (i0 + 9'h001 < state_ff.no) ? i0 + 9'h001 : i0;
        a = scr_mem[i0];
        b = scr_mem[i1];
        diff = $signed({b[15], b}) - $signed({a[15], a});
        prod = $signed({1'b0, frac}) * diff;
        mem_we = 1'b1;
        mem_idx = 9'(state_ff.dofs + state_ff.cnt);
        // Base plus fraction of the step
        mem_wd = state_ff.zero ? 16'sh0000 : a + prod[31:16];
        nxt_state.pos = state_ff.pos +
                        $signed({8'h00, state_ff.dq[18:0]});
        nxt_state.cnt = state_ff.cnt + 9'h001;
        if (state_ff.cnt == state_ff.nn - 9'h001) begin
          nxt_state.job = state_ff.job + 2'h1;
          nxt_state.st = (state_ff.job == `CSSR_LAST_JOB)
                         ? cssr_pkg::st_mode : cssr_pkg::st_setup;
        end
      end
      cssr_pkg::st_mode: begin
        // Flags describe the frame just started
        nxt_state.recomp = 1'b0;
        nxt_state.to_legacy = 1'b0;
        nxt_state.to_primary = 1'b0;
        nxt_state.sid_force = 1'b0;
        nxt_state.ar_reset = 1'b0;
        nxt_state.bwe_reset = 1'b0;
        nxt_state.tmode = cssr_pkg::tm_none;
        if (pr != cr) begin
          if (!(is_std(pr) && is_std(cr))) begin
            // Odd rate involved, state to zero
            nxt_state.wsyn = '0;
          end else if (!keep_br(state_ff.cfg[`CSSR_CFG_BR])) begin
            nxt_state.recomp = 1'b1;
          end
          // Listed bit-rates leave the state alone
        end
        if (ccore == 2'h0 && pcore != 2'h0) begin
          if (one_br(state_ff.cfg[`CSSR_CFG_BR])) begin
            nxt_state.tmode = cssr_pkg::transition_mode_one;
          // Mode by the previous transform kind
          end else if (two_br(state_ff.cfg[`CSSR_CFG_BR])) begin
            nxt_state.tmode =
              (pcore == 2'h1) ? cssr_pkg::transition_mode_two
                              : cssr_pkg::transition_mode_three;
          end
        end
        // Safety-net frames count down after use
        if (state_ff.safety != 2'h0 && pcore == 2'h0) begin
          nxt_state.safety = state_ff.safety - 2'h1;
        end
        if (!state_ff.prev[`CSSR_CFG_LEG] &&
            state_ff.cfg[`CSSR_CFG_LEG]) begin
          // Spectral memories go to immittance form
          nxt_state.to_legacy = 1'b1;
          // Clamp energy index, preset gain memory
          if (state_ff.comfort_noise > `CSSR_CNG_MAX) begin
            nxt_state.comfort_noise = `CSSR_CNG_MAX;
          end
          nxt_state.gain = `CSSR_GAIN_INI;
          nxt_state.ar_reset = 1'b1;
          // Noise segment forces a descriptor frame
          nxt_state.sid_force = state_ff.cfg[`CSSR_CFG_NSEG];
        end
        if (state_ff.prev[`CSSR_CFG_LEG] &&
            !state_ff.cfg[`CSSR_CFG_LEG]) begin
          // Back to line form, resets requested
          nxt_state.to_primary = 1'b1;
          nxt_state.bwe_reset = 1'b1;
          nxt_state.safety = `CSSR_SAFE_N;
        end
        nxt_state.prev = state_ff.cfg;
        nxt_state.st = cssr_pkg::st_idle;
      end
      default: nxt_state.st = cssr_pkg::st_idle;
    endcase
  end

  // Buffer storage, data only, no reset needed
  always_ff @(posedge clk) begin
    if (mem_we) begin
      buf_mem[mem_buf][mem_idx] <= mem_wd;
    end
    if (scr_we) begin
      scr_mem[scr_idx] <= scr_wd;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= '0;
      state_ff.cfg <= `CSSR_CFG_RST;
      state_ff.prev <= `CSSR_CFG_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata = state_ff.rdata;
  assign busy = state_ff.st != cssr_pkg::st_idle;

  // Mode one for the fixed bit-rates
  chk_tmode_one: assert property (@(posedge clk) disable iff (srst)
    state_ff.st == cssr_pkg::st_mode &&
    state_ff.cfg[`CSSR_CFG_CORE] == 2'h0 &&
    state_ff.prev[`CSSR_CFG_CORE] != 2'h0 &&
    one_br(state_ff.cfg[`CSSR_CFG_BR]) |=>
    state_ff.tmode == cssr_pkg::transition_mode_one)
    else $error("transition mode one not selected");
  // Mode two or three by source
  chk_tmode_two_three: assert property (@(posedge clk)
    disable iff (srst)
    state_ff.st == cssr_pkg::st_mode &&
    state_ff.cfg[`CSSR_CFG_CORE] == 2'h0 &&
    state_ff.prev[`CSSR_CFG_CORE] != 2'h0 &&
    two_br(state_ff.cfg[`CSSR_CFG_BR]) |=>
    state_ff.tmode == (($past(state_ff.prev[`CSSR_CFG_CORE]) == 2'h1)
      ? cssr_pkg::transition_mode_two
      : cssr_pkg::transition_mode_three))
    else $error("transition mode two or three wrong");
  // Weighted state cleared for odd rates
  chk_wsyn_clear: assert property (@(posedge clk) disable iff (srst)
    state_ff.st == cssr_pkg::st_mode && state_ff.rsw &&
    !(is_std(state_ff.prev[`CSSR_CFG_RATE]) &&
      is_std(state_ff.cfg[`CSSR_CFG_RATE]))
    |=> state_ff.wsyn == 16'h0000 && !state_ff.recomp)
    else $error("weighted state not cleared");
  chk_wsyn_keep: assert property (@(posedge clk) disable iff (srst)
    state_ff.st == cssr_pkg::st_mode && state_ff.rsw &&
    is_std(state_ff.prev[`CSSR_CFG_RATE]) &&
    is_std(state_ff.cfg[`CSSR_CFG_RATE]) &&
    keep_br(state_ff.cfg[`CSSR_CFG_BR])
    |=> !state_ff.recomp && $stable(state_ff.wsyn))
    else $error("weighted state disturbed");
  chk_legacy_entry: assert property (@(posedge clk)
    disable iff (srst)
    state_ff.st == cssr_pkg::st_mode &&
    !state_ff.prev[`CSSR_CFG_LEG] && state_ff.cfg[`CSSR_CFG_LEG]
    |=> state_ff.gain == `CSSR_GAIN_INI &&
    state_ff.comfort_noise <= `CSSR_CNG_MAX && state_ff.to_legacy)
    else $error("legacy entry presets missing");
  // Descriptor frame forced in noise segment
  chk_sid_force: assert property (@(posedge clk) disable iff (srst)
    state_ff.st == cssr_pkg::st_mode &&
    !state_ff.prev[`CSSR_CFG_LEG] && state_ff.cfg[`CSSR_CFG_LEG] &&
    state_ff.cfg[`CSSR_CFG_NSEG] |=>
    state_ff.sid_force && state_ff.ar_reset)
    else $error("descriptor frame not forced");
  chk_safety_load: assert property (@(posedge clk)
    disable iff (srst)
    state_ff.st == cssr_pkg::st_mode &&
    state_ff.prev[`CSSR_CFG_LEG] && !state_ff.cfg[`CSSR_CFG_LEG]
    |=> state_ff.safety == `CSSR_SAFE_N && state_ff.bwe_reset)
    else $error("safety-net count not loaded");
  // De-emphasis only changes by a write
  chk_deemph_kept: assert property (@(posedge clk)
    disable iff (srst)
    !(wr && addr == `CSSR_A_DEEMPH) |=> $stable(state_ff.deemph))
    else $error("de-emphasis memory changed");
  // Rate switch enters memory work first
  chk_rate_first: assert property (@(posedge clk) disable iff (srst)
    go && (state_ff.prev[`CSSR_CFG_RATE] !=
           state_ff.cfg[`CSSR_CFG_RATE])
    |=> state_ff.st == cssr_pkg::st_setup ##1
    state_ff.st != cssr_pkg::st_mode)
    else $error("rate work not first");
  chk_acb_zero: assert property (@(posedge clk) disable iff (srst)
    state_ff.st == cssr_pkg::st_interp && state_ff.zero
    |-> mem_we && mem_wd == 16'sh0000 && state_ff.job == 2'h1)
    else $error("codebook zero fill wrong");
  chk_busy_bound: assert property (@(posedge clk)
    disable iff (srst)
    state_ff.busy_cnt <= `CSSR_BUSY_MAX)
    else $error("frame-start work too long");
endmodule : cssr_resampler

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic               clk, srst, wr, rd, busy;
  logic        [13:0] addr;
  logic        [31:0] wdata, rdata, d, w, e;
  logic signed [15:0] x [380];  // Codebook 0..255, synth 320..379
  int                 n_errors, check_count, cyc, i, c, b;
  int                 brs [8] = '{1, 2, 3, 4, 5, 6, 7, 9};
  cssr_resampler dut (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy));
  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string s, input logic [31:0] ex, g);
    check_count++;
    if (g !== ex) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", s, ex, g);
    end
  endtask : chk
  task automatic wrr(input logic [13:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  // Read data stands only in the cycle after the strobe
  task automatic rdr(input logic [13:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rdr
  // Write config, start, wait bounded for idle
  task automatic start(input logic [10:0] cf);
    int k;
    wrr(14'h0004, {21'h0, cf});
    wrr(14'h0000, 32'h1);
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 4000) begin
      @(posedge clk);
      #1 k++;
    end
    chk("busy", 32'h0, 32'(busy));
  endtask : start
  // Expected interpolated sample, Q16 position
  function automatic logic [31:0] ip(int o, int no, int nn, int n);
    longint             r, p, k, f;
    logic signed [15:0] a, q, y;
    r = (longint'(no) * 65536) / nn;
    p = (r >>> 1) - 32768 + n * r;
    if (p < 0) p = 0;
    k = p >>> 16;
    f = p & 65535;
    if (k > no - 1) k = no - 1;
    a = x[o + k];
    q = (k + 1 < no) ? x[o + k + 1] : a;
    y = a + 16'((f * (q - a)) >>> 16);
    return {{16{y[15]}}, y};
  endfunction : ip
  initial begin
    srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
    n_errors = 0; check_count = 0;
    void'($urandom(32'h23c0adf4));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rdr(14'h0004); chk("cfg", 32'h1, d);
    rdr(14'h0008); chk("stat", 32'h0, d);
    rdr(14'h0ffc); chk("unmapped", 32'h0, d);
    $display("test reset done");
    // Random codebook and synth history at 12.8 kHz
    for (i = 0; i < 316; i++) begin
      x[i < 256 ? i : i + 64] = 16'($urandom);
      if (i < 256) wrr(14'h2800 + 14'(4 * i), {{16{x[i][15]}}, x[i]});
      else wrr(14'h2000 + 14'(4 * i - 1024),
               {{16{x[i + 64][15]}}, x[i + 64]});
      // Codebook head also seeds the past input buffer
      if (i < 64) wrr(14'h3000 + 14'(4 * i), {{16{x[i][15]}}, x[i]});
    end
    start({1'b0, 4'h3, 2'h0, 1'b0, 3'h2});
    rdr(14'h0008); chk("stat", 32'h3, {29'h0, d[5:3]});
    for (i = 0; i < 320; i++) begin
      rdr(14'h2800 + 14'(4 * i));
      chk("acb", ip(0, 256, 320, i), d);
    end
    for (i = 0; i < 20; i++) begin
      rdr(14'h2000 + 14'(4 * i + 160));
      chk("syn", ip(364, 16, 20, i), d);
    end
    for (i = 0; i < 80; i++) begin
      rdr(14'h3000 + 14'(4 * i));
      chk("past", ip(0, 64, 80, i), d);
    end
    $display("test resample done");
    w = 32'($urandom_range(32767, 1));
    e = 32'($urandom_range(32767, 1));
    wrr(14'h0018, w);
    start({1'b0, 4'h4, 2'h0, 1'b0, 3'h1});
    rdr(14'h0008); chk("recomp", 32'h0, 32'(d[4]));
    rdr(14'h0018); chk("wsyn", w, d);
    wrr(14'h0014, e);
    start({1'b0, 4'h3, 2'h0, 1'b0, 3'h4});
    rdr(14'h0008); chk("stat", 32'h5, {29'h0, d[5:3]});
    rdr(14'h0018); chk("wsyn", 32'h0, d);
    rdr(14'h2800); chk("acb0", 32'h0, d);
    rdr(14'h2cfc); chk("acb319", 32'h0, d);
    rdr(14'h0014); chk("deemph", e, d);
    start({1'b0, 4'h2, 2'h0, 1'b0, 3'h1});
    $display("test weighted done");
    for (c = 1; c < 3; c++) begin
      for (b = 0; b < 8; b++) begin
        start({1'b0, 4'(brs[b]), 2'(c), 1'b0, 3'h1});
        start({1'b0, 4'(brs[b]), 2'h0, 1'b0, 3'h1});
        rdr(14'h0008);
        chk("tmode", (brs[b] == 3 || brs[b] == 5 || brs[b] == 6) ?
          32'(c + 1) : 32'h1, {30'h0, d[2:1]});
      end
    end
    $display("test transition done");
    wrr(14'h000c, 32'($urandom_range(255, 64)));
    start({1'b1, 4'h2, 2'h0, 1'b1, 3'h1});
    rdr(14'h000c); chk("cng", 32'h3f, d);
    rdr(14'h0010); chk("gain", 32'hf200, {16'h0, d[15:0]});
    rdr(14'h0008); chk("entry", 32'h7, {29'h0, d[9:8], d[6]});
    start({1'b0, 4'h2, 2'h0, 1'b0, 3'h1});
    rdr(14'h0008);
    chk("exit", 32'h7, {29'h0, d[11:10], d[7]});
    start({1'b0, 4'h2, 2'h0, 1'b0, 3'h1});
    rdr(14'h0008);
    chk("safety", 32'h2, 32'(d[13:12]));
    $display("test legacy done");
    end_sim();
  end
endmodule : testbench
